/* hdl/oad_pkg.sv */
// Shared types and constants for the operand addressing decoder
package oad_pkg;
    localparam int unsigned REG_W = 16;
    localparam int unsigned REG_N = 16;
    localparam logic [3:0] PC_IDX = 4'h0;
    localparam logic [3:0] STATUS_IDX = 4'h2;
    localparam logic [3:0] CG2_IDX = 4'h3;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] CONST_4 = 16'h0004;
    localparam logic [15:0] CONST_8 = 16'h0008;
    localparam logic [15:0] CONST_0 = 16'h0000;
    localparam logic [15:0] CONST_1 = 16'h0001;
    localparam logic [15:0] CONST_2 = 16'h0002;
    localparam logic [15:0] CONST_M1 = 16'hffff;
    localparam logic [1:0] SM_REG = 2'h0;
    localparam logic [1:0] SM_IDX = 2'h1;
    localparam logic [1:0] SM_IND = 2'h2;
    localparam logic [1:0] SM_INC = 2'h3;
    localparam logic [1:0] LEN_ONE = 2'h1;

    // One decoded two-operand instruction, a move of source to destination
    typedef struct packed {
        logic [3:0] src_reg;
        logic [1:0] source_mode_field;
        logic [3:0] dst_reg;
        logic dst_mode;
        logic byte_op;
    } oad_instr_t;

    // Memory request presented to the bus
    typedef struct packed {
        logic req;
        logic we;
        logic byte_op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } oad_mem_req_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SRC_EXT, ST_SRC_RD, ST_DST_EXT, ST_DST_WR, ST_DONE
    } oad_state_t;
endpackage : oad_pkg

/* hdl/oad_decoder.sv */
// Operand addressing decoder, register file and effective address unit
// Operation
// - Second constant source, mode 00 gives zero
// - Constant sources yield 4,8,0,1,2,all-ones only
// - Twelve working registers: data, pointer, index, byte/word
// - Seven source modes, four destination modes
// - Mode 00/0 operand is register contents
// - Mode 01/1 fetches offset, accesses register plus offset
// - Symbolic mode is indexed on program counter
// - Absolute mode is indexed on status register
// - Source mode 10 uses register as address
// - Source mode 11 post-increments by 1 or 2
// - Immediate is autoincrement through program counter
// - Any source mode pairs with any destination
// - Register move leaves source register unchanged
// - Byte register write clears upper byte, byte flags
// - Index bases unchanged, PC skips extension words
// - Length is one word plus extension words
`timescale 1ns/100ps
module oad_decoder #(
    parameter int unsigned DATA_W = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_start,
    input wire oad_pkg::oad_instr_t i_instr,
    input wire logic i_mem_ack,
    input wire logic [15:0] i_mem_rdata,
    output oad_pkg::oad_mem_req_t o_mem,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_operand,
    output logic [1:0] o_length,
    output logic o_flag_n,
    output logic o_flag_z,
    output logic [15:0] o_pc
);
    // Datapath is fixed at the register width
    if (DATA_W != oad_pkg::REG_W) begin : g_width_check
        $error("DATA_W must equal the 16-bit register width");
    end

    // Constant source test; shared by start decode and checks
    function automatic logic is_const(input logic [3:0] r,
                                      input logic [1:0] m);
        is_const = (r == oad_pkg::CG2_IDX) ||
            (r == oad_pkg::STATUS_IDX && m[1]);
    endfunction : is_const

    function automatic logic [15:0] const_val(input logic [3:0] r,
                                              input logic [1:0] m);
        if (r == oad_pkg::STATUS_IDX) begin
            const_val = m[0] ? oad_pkg::CONST_8 : oad_pkg::CONST_4;
        end else begin
            unique case (m)
                2'h0: const_val = oad_pkg::CONST_0;
                2'h1: const_val = oad_pkg::CONST_1;
                2'h2: const_val = oad_pkg::CONST_2;
                default: const_val = oad_pkg::CONST_M1;
            endcase
        end
    endfunction : const_val

    // Status register base reads as zero so the offset is the address
    function automatic logic [15:0] idx_base(input logic [3:0] r,
                                             input logic [15:0] v);
        idx_base = (r == oad_pkg::STATUS_IDX) ? 16'h0000 : v;
    endfunction : idx_base

    oad_pkg::oad_state_t state_q;
    oad_pkg::oad_instr_t ins_q;
    logic [15:0] regs_q [oad_pkg::REG_N];
    logic [15:0] op_q;
    logic [1:0] len_q;
    logic src_ext_ack;
    logic dst_ext_ack;
    logic inc_fire;
    logic reg_wr;
    logic [15:0] step;
    logic [15:0] wr_val;
    logic src_direct;

    assign src_ext_ack = state_q == oad_pkg::ST_SRC_EXT && i_mem_ack;
    assign dst_ext_ack = state_q == oad_pkg::ST_DST_EXT && i_mem_ack;
    assign inc_fire = i_clk_en && state_q == oad_pkg::ST_IDLE && i_start &&
        i_instr.source_mode_field == oad_pkg::SM_INC &&
        !is_const(i_instr.src_reg, i_instr.source_mode_field);
    assign src_direct = is_const(i_instr.src_reg, i_instr.source_mode_field) ||
        i_instr.source_mode_field == oad_pkg::SM_REG;
    // Program counter always steps by a word, even for byte immediates
    assign step = (i_instr.byte_op && i_instr.src_reg != oad_pkg::PC_IDX) ?
        oad_pkg::BYTE_STEP : oad_pkg::WORD_STEP;
    assign reg_wr = state_q == oad_pkg::ST_DST_WR && !ins_q.dst_mode;
    assign wr_val = ins_q.byte_op ? {8'h00, op_q[7:0]} : op_q;

    // Sequencer: source phase, then destination phase
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= oad_pkg::ST_IDLE;
        end else if (i_clk_en) begin
            unique case (state_q)
                oad_pkg::ST_IDLE: if (i_start) begin
                    if (src_direct) begin
                        state_q <= i_instr.dst_mode ?
                            oad_pkg::ST_DST_EXT : oad_pkg::ST_DST_WR;
                    end else if (i_instr.source_mode_field ==
                                 oad_pkg::SM_IDX) begin
                        state_q <= oad_pkg::ST_SRC_EXT;
                    end else begin
                        state_q <= oad_pkg::ST_SRC_RD;
                    end
                end
                oad_pkg::ST_SRC_EXT: if (i_mem_ack) begin
                    state_q <= oad_pkg::ST_SRC_RD;
                end
                // Any source mode may pair with either destination mode
                oad_pkg::ST_SRC_RD: if (i_mem_ack) begin
                    state_q <= ins_q.dst_mode ?
                        oad_pkg::ST_DST_EXT : oad_pkg::ST_DST_WR;
                end
                oad_pkg::ST_DST_EXT: if (i_mem_ack) begin
                    state_q <= oad_pkg::ST_DST_WR;
                end
                oad_pkg::ST_DST_WR: if (!ins_q.dst_mode || i_mem_ack) begin
                    state_q <= oad_pkg::ST_DONE;
                end
                // Done and any stray code fall back to idle
                default: state_q <= oad_pkg::ST_IDLE;
            endcase
        end
    end

    // Instruction capture and length count
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ins_q <= '0;
            len_q <= oad_pkg::LEN_ONE;
        end else if (i_clk_en) begin
            if (state_q == oad_pkg::ST_IDLE && i_start) begin
                ins_q <= i_instr;
                len_q <= (inc_fire && i_instr.src_reg == oad_pkg::PC_IDX) ?
                    oad_pkg::LEN_ONE + 2'h1 : oad_pkg::LEN_ONE;
            end else if (src_ext_ack || dst_ext_ack) begin
                len_q <= len_q + 2'h1;
            end
        end
    end

    // Register file; PC lives at index zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            regs_q <= '{default: oad_pkg::REG_RESET};
            regs_q[0] <= oad_pkg::PC_RESET;
        end else if (i_clk_en) begin
            if (inc_fire) begin
                regs_q[i_instr.src_reg] <=
                    regs_q[i_instr.src_reg] + step;
            end else if (src_ext_ack || dst_ext_ack) begin
                regs_q[0] <= regs_q[0] + oad_pkg::WORD_STEP;
            end else if (reg_wr) begin
                regs_q[ins_q.dst_reg] <= wr_val;
            end
        end
    end

    // Operand value and bus request
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            op_q <= 16'h0000;
            o_mem <= '0;
        end else if (i_clk_en) begin
            unique case (state_q)
                oad_pkg::ST_IDLE: if (i_start) begin
                    o_mem.byte_op <= i_instr.byte_op;
                    o_mem.we <= 1'b0;
                    if (is_const(i_instr.src_reg,
                                 i_instr.source_mode_field)) begin
                        op_q <= const_val(i_instr.src_reg,
                            i_instr.source_mode_field);
                    end else if (i_instr.source_mode_field ==
                                 oad_pkg::SM_REG) begin
                        op_q <= regs_q[i_instr.src_reg];
                    end else begin
                        o_mem.req <= 1'b1;
                        o_mem.addr <= (i_instr.source_mode_field ==
                            oad_pkg::SM_IDX) ? regs_q[0] :
                            regs_q[i_instr.src_reg];
                    end
                    if (i_instr.dst_mode && src_direct) begin
                        o_mem.req <= 1'b1;
                        o_mem.addr <= regs_q[0];
                    end
                end
                // Base taken before PC moves past the offset word
                oad_pkg::ST_SRC_EXT: if (i_mem_ack) begin
                    o_mem.addr <= idx_base(ins_q.src_reg,
                        regs_q[ins_q.src_reg]) + i_mem_rdata;
                end
                oad_pkg::ST_SRC_RD: if (i_mem_ack) begin
                    op_q <= i_mem_rdata;
                    o_mem.req <= ins_q.dst_mode;
                    o_mem.addr <= regs_q[0];
                end
                oad_pkg::ST_DST_EXT: if (i_mem_ack) begin
                    o_mem.we <= 1'b1;
                    o_mem.wdata <= op_q;
                    o_mem.addr <= idx_base(ins_q.dst_reg,
                        regs_q[ins_q.dst_reg]) + i_mem_rdata;
                end
                oad_pkg::ST_DST_WR: if (i_mem_ack) begin
                    o_mem.req <= 1'b0;
                    o_mem.we <= 1'b0;
                end
                default: o_mem.req <= 1'b0;
            endcase
        end
    end

    // Completion outputs; flags follow the operation width
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done <= 1'b0;
            o_operand <= 16'h0000;
            o_length <= oad_pkg::LEN_ONE;
            o_flag_n <= 1'b0;
            o_flag_z <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= state_q == oad_pkg::ST_DST_WR &&
                (!ins_q.dst_mode || i_mem_ack);
            if (state_q == oad_pkg::ST_DST_WR) begin
                o_operand <= wr_val;
                o_length <= len_q;
                o_flag_n <= ins_q.byte_op ? op_q[7] : op_q[15];
                o_flag_z <= ins_q.byte_op ? op_q[7:0] == 8'h00 :
                    op_q == 16'h0000;
            end
        end
    end

    // Busy and program counter mirrors
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_busy <= 1'b0;
            o_pc <= oad_pkg::PC_RESET;
        end else if (i_clk_en) begin
            o_busy <= (state_q == oad_pkg::ST_IDLE) ? i_start :
                state_q != oad_pkg::ST_DONE;
            o_pc <= regs_q[0];
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    AST_CG_ZERO: assert property (i_clk_en && state_q == oad_pkg::ST_IDLE &&
        i_start && i_instr.src_reg == oad_pkg::CG2_IDX &&
        i_instr.source_mode_field == oad_pkg::SM_REG && !i_instr.dst_mode
        |=> op_q == 16'h0000 && !o_mem.req)
        else $error("zero constant wrong or fetched");
    AST_CG_MINUS: assert property (i_clk_en && state_q == oad_pkg::ST_IDLE &&
        i_start && i_instr.src_reg == oad_pkg::CG2_IDX &&
        i_instr.source_mode_field == oad_pkg::SM_INC
        |=> op_q == 16'hffff)
        else $error("all-ones constant wrong");
    AST_REG_SRC: assert property (i_clk_en && state_q == oad_pkg::ST_IDLE &&
        i_start && i_instr.source_mode_field == oad_pkg::SM_REG &&
        !is_const(i_instr.src_reg, i_instr.source_mode_field)
        |=> op_q == $past(regs_q[i_instr.src_reg]))
        else $error("register operand wrong");
    AST_IDX_FETCH: assert property (i_clk_en && state_q == oad_pkg::ST_IDLE &&
        i_start && i_instr.source_mode_field == oad_pkg::SM_IDX &&
        !is_const(i_instr.src_reg, i_instr.source_mode_field)
        |=> o_mem.req && o_mem.addr == $past(regs_q[0]))
        else $error("offset word not fetched at PC");
    AST_PC_SKIP: assert property (i_clk_en && (src_ext_ack || dst_ext_ack)
        |=> regs_q[0] == $past(regs_q[0]) + 16'h0002)
        else $error("PC did not skip offset word");
    AST_ABS: assert property (i_clk_en && src_ext_ack &&
        ins_q.src_reg == oad_pkg::STATUS_IDX
        |=> o_mem.addr == $past(i_mem_rdata))
        else $error("absolute address not the offset");
    AST_BYTE_WR: assert property (i_clk_en && reg_wr && ins_q.byte_op
        |=> regs_q[ins_q.dst_reg][15:8] == 8'h00)
        else $error("byte write left upper byte");
    AST_DONE_LEN: assert property (i_clk_en && o_done
        |-> o_length >= 2'h1 && o_length <= 2'h3)
        else $error("instruction length out of range");
    AST_INC: assert property (inc_fire && i_instr.src_reg != oad_pkg::PC_IDX
        |=> regs_q[$past(i_instr.src_reg)] ==
            $past(regs_q[i_instr.src_reg]) + $past(step))
        else $error("autoincrement step wrong");

    COV_IMM: cover property (inc_fire && i_instr.src_reg == oad_pkg::PC_IDX);
    COV_IDX_IDX: cover property (o_done && o_length == 2'h3);
    COV_CONST: cover property (state_q == oad_pkg::ST_IDLE && i_start &&
        is_const(i_instr.src_reg, i_instr.source_mode_field));
    COV_BYTE: cover property (reg_wr && ins_q.byte_op);
endmodule : oad_decoder

/* tb/tb.sv */
// Self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s: exp %h seen %h", w, e, g); end end
module tb;
    logic i_clock;
    logic i_rst_b;
    logic i_clk_en;
    logic i_start;
    oad_pkg::oad_instr_t i_instr;
    logic i_mem_ack;
    logic [15:0] i_mem_rdata;
    oad_pkg::oad_mem_req_t o_mem;
    logic o_busy, o_done, o_flag_n, o_flag_z;
    logic [15:0] o_operand, o_pc;
    logic [1:0] o_length;
    logic [15:0] mem [0:32767];
    logic [32:0] acc_q[$];
    logic [15:0] pc;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    oad_decoder oad_decoder_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en), .i_start(i_start), .i_instr(i_instr),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem),
        .o_busy(o_busy), .o_done(o_done), .o_operand(o_operand),
        .o_length(o_length), .o_flag_n(o_flag_n), .o_flag_z(o_flag_z),
        .o_pc(o_pc));

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    // Memory answers one cycle after a request, then idles one cycle
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            i_mem_ack <= 1'b0;
        end else if (o_mem.req && !i_mem_ack) begin
            i_mem_ack <= 1'b1;
            i_mem_rdata <= mem[o_mem.addr[15:1]];
            acc_q.push_back({o_mem.we, o_mem.addr, o_mem.wdata});
            if (o_mem.we) mem[o_mem.addr[15:1]] = o_mem.wdata;
        end else begin
            i_mem_ack <= 1'b0;
            i_mem_rdata <= ~i_mem_rdata; // Stale data never looks valid
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Extension word at the current program counter plus k words
    task automatic put(int k, logic [15:0] v);
        mem[pc[15:1] + 15'(k)] = v;
    endtask : put

    task automatic run(logic [3:0] s, logic [1:0] m, logic [3:0] d,
                       logic dm, logic b);
        acc_q.delete();
        @(posedge i_clock);
        i_instr <= '{src_reg: s, source_mode_field: m, dst_reg: d,
                     dst_mode: dm, byte_op: b};
        i_start <= 1'b1;
        @(posedge i_clock);
        i_start <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge i_clock);
            #1;
            if (o_done === 1'b1) break;
        end
        `CHK("done", 1'b1, o_done)
        `CHK("busy", 1'b1, o_busy)
    endtask : run

    task automatic exp(logic [15:0] op, logic [1:0] len, int n);
        `CHK("operand", op, o_operand)
        `CHK("length", len, o_length)
        `CHK("accesses", n, acc_q.size())
    endtask : exp

    task automatic acc(int i, logic we, logic [15:0] a);
        `CHK("access", {we, a}, acc_q[i][32:16])
    endtask : acc

    // Immediate loads, then register moves
    task automatic t_imm_reg();
        logic [15:0] v [3] = '{16'h1080, 16'h108c, 16'h8000};
        for (int i = 0; i < 3; i++) begin
            put(0, v[i]);
            run(4'h0, 2'h3, 4'(5 + i), 1'b0, 1'b0);
            exp(v[i], 2'h2, 1);
            acc(0, 1'b0, pc);
            pc += 16'h0002;
        end
        run(4'h5, 2'h0, 4'hb, 1'b0, 1'b0);
        exp(16'h1080, 2'h1, 0);
        run(4'hb, 2'h0, 4'hc, 1'b0, 1'b0);
        exp(16'h1080, 2'h1, 0);
        run(4'h5, 2'h0, 4'hd, 1'b0, 1'b0);
        exp(16'h1080, 2'h1, 0);
        repeat (2) @(posedge i_clock);
        #1;
        `CHK("pc", pc, o_pc)
        $display("test imm_reg done");
    endtask : t_imm_reg

    // Six constants, no fetch, flags from the value
    task automatic t_const();
        logic [3:0] r [6] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2};
        logic [1:0] m [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
        logic [15:0] c [6] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff,
                               16'h0004, 16'h0008};
        for (int i = 0; i < 6; i++) begin
            run(r[i], m[i], 4'h8, 1'b0, 1'b0);
            exp(c[i], 2'h1, 0);
            `CHK("z", c[i] == 16'h0000, o_flag_z)
            `CHK("n", c[i][15], o_flag_n)
        end
        @(posedge i_clock);
        #1;
        `CHK("idle", 1'b0, o_busy)
        $display("test const done");
    endtask : t_const

    // Indexed source and destination, bases untouched
    task automatic t_indexed();
        mem[16'h1082 >> 1] = 16'h1234;
        put(0, 16'h0002);
        put(1, 16'h0006);
        run(4'h5, 2'h1, 4'h6, 1'b1, 1'b0);
        exp(16'h1234, 2'h3, 4);
        acc(0, 1'b0, pc);
        acc(1, 1'b0, 16'h1082);
        acc(2, 1'b0, pc + 16'h0002);
        acc(3, 1'b1, 16'h1092);
        `CHK("wdata", 16'h1234, acc_q[3][15:0])
        pc += 16'h0004;
        run(4'h5, 2'h0, 4'h4, 1'b0, 1'b0);
        exp(16'h1080, 2'h1, 0);
        run(4'h6, 2'h0, 4'h4, 1'b0, 1'b0);
        exp(16'h108c, 2'h1, 0);
        repeat (2) @(posedge i_clock);
        #1;
        `CHK("pc", pc, o_pc)
        $display("test indexed done");
    endtask : t_indexed

    // Symbolic uses the extension address, absolute uses zero base
    task automatic t_sym_abs();
        mem[(pc + 16'h0100) >> 1] = 16'h5a5a;
        put(0, 16'h0100);
        run(4'h0, 2'h1, 4'h9, 1'b0, 1'b0);
        exp(16'h5a5a, 2'h2, 2);
        acc(1, 1'b0, pc + 16'h0100);
        pc += 16'h0002;
        mem[16'h2000 >> 1] = 16'h6b6b;
        put(0, 16'h2000);
        run(4'h2, 2'h1, 4'ha, 1'b0, 1'b0);
        exp(16'h6b6b, 2'h2, 2);
        acc(1, 1'b0, 16'h2000);
        pc += 16'h0002;
        put(0, 16'h2010);
        run(4'h5, 2'h0, 4'h2, 1'b1, 1'b0);
        exp(16'h1080, 2'h2, 2);
        acc(1, 1'b1, 16'h2010);
        pc += 16'h0002;
        $display("test sym_abs done");
    endtask : t_sym_abs

    // Indirect, autoincrement by word and byte, byte register writes
    task automatic t_indirect();
        mem[16'h1080 >> 1] = 16'h4321;
        mem[16'h108c >> 1] = 16'h12f0;
        run(4'h5, 2'h2, 4'h4, 1'b0, 1'b0);
        exp(16'h4321, 2'h1, 1);
        acc(0, 1'b0, 16'h1080);
        run(4'h5, 2'h3, 4'h4, 1'b0, 1'b0);
        exp(16'h4321, 2'h1, 1);
        run(4'h5, 2'h0, 4'h4, 1'b0, 1'b0);
        exp(16'h1082, 2'h1, 0);
        run(4'h6, 2'h3, 4'h4, 1'b0, 1'b1);
        exp(16'h00f0, 2'h1, 1);
        `CHK("n", 1'b1, o_flag_n)
        `CHK("byte_op", 1'b1, o_mem.byte_op)
        run(4'h6, 2'h0, 4'h4, 1'b0, 1'b0);
        exp(16'h108d, 2'h1, 0);
        run(4'h7, 2'h0, 4'h4, 1'b0, 1'b1);
        exp(16'h0000, 2'h1, 0);
        `CHK("z", 1'b1, o_flag_z)
        `CHK("n", 1'b0, o_flag_n)
        run(4'h7, 2'h0, 4'h4, 1'b0, 1'b0);
        `CHK("n", 1'b1, o_flag_n)
        $display("test indirect done");
    endtask : t_indirect

    // Main sequence
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'ha5c3;
        i_rst_b = 1'b0;
        i_clk_en = 1'b1;
        i_start = 1'b0;
        i_instr = '0;
        i_mem_rdata = 16'h0000;
        pc = 16'h0000;
        repeat (3) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_imm_reg();
        t_const();
        t_indexed();
        t_sym_abs();
        t_indirect();
        finish_test();
    end
endmodule : tb
